// ===== tnmc_pkg.sv
// shared constants and types of the transmit carrier and correction back end
// assumes byte-wide register access and one dac-rate sample per clock
package tnmc_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE_SELECT = 8'h1e;
    localparam logic [7:0] ADDR_I_PHASE_LO = 8'h28;
    localparam logic [7:0] ADDR_I_PHASE_HI = 8'h29;
    localparam logic [7:0] ADDR_Q_PHASE_LO = 8'h2a;
    localparam logic [7:0] ADDR_Q_PHASE_HI = 8'h2b;
    localparam logic [7:0] ADDR_I_SHIFT_LO = 8'h2c;
    localparam logic [7:0] ADDR_I_SHIFT_HI = 8'h2d;
    localparam logic [7:0] ADDR_Q_SHIFT_LO = 8'h2e;
    localparam logic [7:0] ADDR_Q_SHIFT_HI = 8'h2f;
    localparam logic [7:0] ADDR_I_SCALE = 8'h50;
    localparam logic [7:0] ADDR_Q_SCALE = 8'h51;
    localparam logic [7:0] ADDR_STEP_B0 = 8'h54;
    localparam logic [7:0] ADDR_STEP_B1 = 8'h55;
    localparam logic [7:0] ADDR_STEP_B2 = 8'h56;
    localparam logic [7:0] ADDR_STEP_B3 = 8'h57;
    localparam logic [7:0] ADDR_SHIFT_LO = 8'h58;
    localparam logic [7:0] ADDR_SHIFT_HI = 8'h59;
    localparam logic [7:0] ADDR_COMMIT = 8'h5a;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 2;
    localparam int NCO_EN_BIT = 3;
    localparam int COMMIT_BIT = 2;
    localparam int PHADJ_HI_MSB = 1;
    localparam logic [7:0] SCALE_RESET = 8'h40;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // datapath constants
    // ----------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int ROM_ADDR_W = 6;
    localparam int GAIN_FRAC = 6;
    // phase correction: 1.75 deg at code 511 -> 1001 / 2^24 per code
    localparam logic [11:0] PHADJ_K = 12'h3e9;
    localparam int PHADJ_SHIFT = 24;
    localparam int LATENCY = 6;

    typedef struct packed {
        logic signed [15:0] i;
        logic signed [15:0] q;
    } tnmc_iq_type;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tnmc_reg_req_type;

endpackage

// ===== tnmc_wave_rom.sv
// quarter-wave sine table giving registered sine and cosine of a phase
// assumes the phase is the top bits of the carrier phase, one read a clock
`timescale 1ns/1ps
`default_nettype none
module tnmc_wave_rom #(
    parameter int ADDR_W = 6
) (
    input wire logic clk,
    input wire logic [ADDR_W-1:0] phase,
    output logic signed [15:0] sin_q,
    output logic signed [15:0] cos_q
);

    // ----------------------------------------------------------------
    // table lookup
    // ----------------------------------------------------------------
    // half-step sampled so no entry sits on zero or full scale
    function automatic logic signed [15:0] quarter(input logic [3:0] k);
        logic [15:0] v;
        v = 16'h0000;
        unique case (k)
            4'h0: v = 16'h0648;
            4'h1: v = 16'h12c8;
            4'h2: v = 16'h1f1a;
            4'h3: v = 16'h2b1f;
            4'h4: v = 16'h36ba;
            4'h5: v = 16'h41ce;
            4'h6: v = 16'h4c3f;
            4'h7: v = 16'h55f5;
            4'h8: v = 16'h5ed7;
            4'h9: v = 16'h66cf;
            4'ha: v = 16'h6dc9;
            4'hb: v = 16'h73b5;
            4'hc: v = 16'h7884;
            4'hd: v = 16'h7c29;
            4'he: v = 16'h7e9c;
            4'hf: v = 16'h7fd8;
        endcase
        return v;
    endfunction

    // full-wave sine from quadrant folding
    function automatic logic signed [15:0] wave(input logic [5:0] p);
        logic [3:0] k;
        logic signed [15:0] m;
        k = p[4] ? ~p[3:0] : p[3:0];
        m = quarter(k);
        return p[5] ? -m : m;
    endfunction

    // ----------------------------------------------------------------
    // registered read
    // ----------------------------------------------------------------
    // cosine is sine a quarter turn later
    always_ff @(posedge clk) begin
        sin_q <= wave(phase[5:0]);
        cos_q <= wave(phase[5:0] + 6'h10);
    end

endmodule
`default_nettype wire

// ===== tnmc_top.sv
// carrier rotation, quadrature phase correction, level shift and scaling
// assumes one interpolated sample per dac clock and byte register access
// Functional notes
// R1 - third half-band stage has eight modes behaving like second stage's
// R2 - 8x mode n pairs stage2 mode 2n mod 8, stage1 2(n mod 2)
// R3 - third stage pass band 40% of input rate, 0.001 dB, 85 dB
// R4 - centered carrier keeps full 0.8 x data rate bandwidth
// R5 - oscillator at dac rate gives cosine and sine, dc to half rate
// R6 - 32-bit step word over four bytes sets carrier frequency
// R7 - complex mixer multiplies by carrier, sums cross products
// R8 - new step word takes effect on 0 to 1 of commit bit 2
// R9 - 16-bit static phase shift added to accumulator before lookup
// R10 - 10-bit i phase code rotates i relative to q by up to 1.75 deg
// R11 - 10-bit q phase code rotates q relative to i likewise
// R12 - both codes together span plus minus 3.5 deg
// R13 - 16-bit i and q level shifts added to the samples
// R14 - final 8-bit scale factor per channel before each converter
// R15 - scale code is unsigned, value code divided by 64
// R16 - software keeps gain and level shift within converter range
// R17 - second stage steps center by quarter rate, modes 4-7 modulate
// R18 - first stage steps center by half rate, modes 2,3 modulate
// R19 - accumulator adds active step word every clock, wraps 2^32
// R20 - level shift and scaling saturate rather than wrap
// R21 - order: rotation, mixer, phase fix, level shift, then scaling
`timescale 1ns/1ps
`default_nettype none
module tnmc_top #(
    parameter int ACC_W = 32
) (
    input wire logic clk,
    input wire logic resetn,
    input wire tnmc_pkg::tnmc_reg_req_type reg_req,
    output logic [7:0] reg_rdata_q,
    input wire logic in_valid,
    input wire tnmc_pkg::tnmc_iq_type in_sample,
    output logic [2:0] first_halfband_mode,
    output logic [2:0] second_halfband_mode,
    output logic out_valid,
    output tnmc_pkg::tnmc_iq_type out_sample_q
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // clip a wide signed value into sample range
    function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
        if (v > 40'sh0000007fff) begin
            return 16'sh7fff;
        end else if (v < -40'sh0000008000) begin
            return -16'sh8000;
        end
        return v[15:0];
    endfunction

    // small-angle shear: own + code * other * k / 2^24
    function automatic logic signed [15:0] shear(
        input logic signed [15:0] own,
        input logic signed [15:0] other,
        input logic signed [9:0] code
    );
        logic signed [39:0] p;
        p = 40'(other) * 40'(code) * 40'(signed'({1'b0, tnmc_pkg::PHADJ_K}));
        return sat16(40'(own) + (p >>> tnmc_pkg::PHADJ_SHIFT));
    endfunction

    // unsigned q2.6 scaling of one sample
    function automatic logic signed [15:0] scale(
        input logic signed [15:0] s,
        input logic [7:0] g
    );
        logic signed [39:0] p;
        p = 40'(s) * 40'(signed'({1'b0, g}));
        return sat16(p >>> tnmc_pkg::GAIN_FRAC);
    endfunction

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [7:0] mode_q;
    logic [9:0] i_phadj_q;
    logic [9:0] q_phadj_q;
    logic [15:0] i_shift_q;
    logic [15:0] q_shift_q;
    logic [7:0] i_scale_q;
    logic [7:0] q_scale_q;
    logic [31:0] step_staged_q;
    logic [15:0] phase_shift_q;
    logic [7:0] commit_q;
    logic [31:0] step_active_q;
    logic commit_rise;

    // plain configuration writes take effect at once
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mode_q <= tnmc_pkg::BYTE_RESET;
            i_phadj_q <= 10'h000;
            q_phadj_q <= 10'h000;
            i_shift_q <= 16'h0000;
            q_shift_q <= 16'h0000;
            i_scale_q <= tnmc_pkg::SCALE_RESET;
            q_scale_q <= tnmc_pkg::SCALE_RESET;
            step_staged_q <= 32'h0000_0000;
            phase_shift_q <= 16'h0000;
            commit_q <= tnmc_pkg::BYTE_RESET;
        end else if (reg_req.wr_en) begin
            unique case (reg_req.addr)
                tnmc_pkg::ADDR_MODE_SELECT: mode_q <= reg_req.wdata;
                tnmc_pkg::ADDR_I_PHASE_LO: i_phadj_q[7:0] <= reg_req.wdata;
                tnmc_pkg::ADDR_I_PHASE_HI: i_phadj_q[9:8] <= reg_req.wdata[1:0];
                tnmc_pkg::ADDR_Q_PHASE_LO: q_phadj_q[7:0] <= reg_req.wdata;
                tnmc_pkg::ADDR_Q_PHASE_HI: q_phadj_q[9:8] <= reg_req.wdata[1:0];
                tnmc_pkg::ADDR_I_SHIFT_LO: i_shift_q[7:0] <= reg_req.wdata;
                tnmc_pkg::ADDR_I_SHIFT_HI: i_shift_q[15:8] <= reg_req.wdata;
                tnmc_pkg::ADDR_Q_SHIFT_LO: q_shift_q[7:0] <= reg_req.wdata;
                tnmc_pkg::ADDR_Q_SHIFT_HI: q_shift_q[15:8] <= reg_req.wdata;
                tnmc_pkg::ADDR_I_SCALE: i_scale_q <= reg_req.wdata;   // [R14]
                tnmc_pkg::ADDR_Q_SCALE: q_scale_q <= reg_req.wdata;   // [R14]
                tnmc_pkg::ADDR_STEP_B0: step_staged_q[7:0] <= reg_req.wdata;
                tnmc_pkg::ADDR_STEP_B1: step_staged_q[15:8] <= reg_req.wdata;
                tnmc_pkg::ADDR_STEP_B2: step_staged_q[23:16] <= reg_req.wdata;
                tnmc_pkg::ADDR_STEP_B3: step_staged_q[31:24] <= reg_req.wdata;
                tnmc_pkg::ADDR_SHIFT_LO: phase_shift_q[7:0] <= reg_req.wdata;
                tnmc_pkg::ADDR_SHIFT_HI: phase_shift_q[15:8] <= reg_req.wdata;
                tnmc_pkg::ADDR_COMMIT: commit_q <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // the step word bytes stay staged until the commit bit rises
    assign commit_rise = reg_req.wr_en
        && reg_req.addr == tnmc_pkg::ADDR_COMMIT
        && reg_req.wdata[tnmc_pkg::COMMIT_BIT]
        && !commit_q[tnmc_pkg::COMMIT_BIT];                       // [R8]

    always_ff @(posedge clk) begin
        if (!resetn) begin
            step_active_q <= 32'h0000_0000;
        end else if (commit_rise) begin
            step_active_q <= step_staged_q;                        // [R6] [R8]
        end
    end

    // readback of the staged values; unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_req.rd_en) begin
            unique case (reg_req.addr)
                tnmc_pkg::ADDR_MODE_SELECT: reg_rdata_q <= mode_q;
                tnmc_pkg::ADDR_I_PHASE_LO: reg_rdata_q <= i_phadj_q[7:0];
                tnmc_pkg::ADDR_I_PHASE_HI: reg_rdata_q <= {6'h00, i_phadj_q[9:8]};
                tnmc_pkg::ADDR_Q_PHASE_LO: reg_rdata_q <= q_phadj_q[7:0];
                tnmc_pkg::ADDR_Q_PHASE_HI: reg_rdata_q <= {6'h00, q_phadj_q[9:8]};
                tnmc_pkg::ADDR_I_SHIFT_LO: reg_rdata_q <= i_shift_q[7:0];
                tnmc_pkg::ADDR_I_SHIFT_HI: reg_rdata_q <= i_shift_q[15:8];
                tnmc_pkg::ADDR_Q_SHIFT_LO: reg_rdata_q <= q_shift_q[7:0];
                tnmc_pkg::ADDR_Q_SHIFT_HI: reg_rdata_q <= q_shift_q[15:8];
                tnmc_pkg::ADDR_I_SCALE: reg_rdata_q <= i_scale_q;
                tnmc_pkg::ADDR_Q_SCALE: reg_rdata_q <= q_scale_q;
                tnmc_pkg::ADDR_STEP_B0: reg_rdata_q <= step_staged_q[7:0];
                tnmc_pkg::ADDR_STEP_B1: reg_rdata_q <= step_staged_q[15:8];
                tnmc_pkg::ADDR_STEP_B2: reg_rdata_q <= step_staged_q[23:16];
                tnmc_pkg::ADDR_STEP_B3: reg_rdata_q <= step_staged_q[31:24];
                tnmc_pkg::ADDR_SHIFT_LO: reg_rdata_q <= phase_shift_q[7:0];
                tnmc_pkg::ADDR_SHIFT_HI: reg_rdata_q <= phase_shift_q[15:8];
                tnmc_pkg::ADDR_COMMIT: reg_rdata_q <= commit_q;
                default: reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // half-band mode pairing
    // ----------------------------------------------------------------
    logic [2:0] s3_mode;
    logic rotate_en;
    assign s3_mode = mode_q[tnmc_pkg::MODE_MSB:tnmc_pkg::MODE_LSB];
    // earlier stages follow the third stage's mode in 8x operation
    assign second_halfband_mode = {s3_mode[1:0], 1'b0};          // [R2] [R17]
    assign first_halfband_mode = {1'b0, s3_mode[0], 1'b0};       // [R2] [R18]
    // mode 0 with the oscillator off passes samples through the mixer untouched
    assign rotate_en = mode_q[tnmc_pkg::NCO_EN_BIT] || s3_mode != 3'h0;

    // ----------------------------------------------------------------
    // phase generation
    // ----------------------------------------------------------------
    logic [ACC_W-1:0] nco_acc_q;
    logic [ACC_W-1:0] mode_acc_q;
    logic [ACC_W-1:0] phase_q;
    logic signed [15:0] sin_v;
    logic signed [15:0] cos_v;

    // accumulators at the dac rate, wrapping naturally; mode_acc_q free-runs, nco_acc_q steps only with the oscillator enabled
    always_ff @(posedge clk) begin
        if (!resetn) begin
            nco_acc_q <= '0;
            mode_acc_q <= '0;
        end else begin
            if (mode_q[tnmc_pkg::NCO_EN_BIT]) begin
                nco_acc_q <= nco_acc_q + step_active_q;           // [R19] [R5]
            end
            // mode n steps n eighths of a turn per clock: n x fdac/8
            mode_acc_q <= mode_acc_q
                + {s3_mode, {(ACC_W-3){1'b0}}};                  // [R1] [R2]
        end
    end

    // static shift joins the accumulator before the table lookup
    always_ff @(posedge clk) begin
        if (!resetn) begin
            phase_q <= '0;
        end else begin
            phase_q <= nco_acc_q + mode_acc_q
                + {phase_shift_q, {(ACC_W-16){1'b0}}};            // [R9]
        end
    end

    // quadrature pair 90 degrees apart; coarse table trades spur level
    // for area
    // table sits half a step in: phase 0 leans 1/128 turn
    tnmc_wave_rom #(
        .ADDR_W(tnmc_pkg::ROM_ADDR_W)
    ) u_wave_rom (
        .clk(clk),
        .phase(phase_q[ACC_W-1 -: tnmc_pkg::ROM_ADDR_W]),        // [R5]
        .sin_q(sin_v),
        .cos_q(cos_v)
    );

    // ----------------------------------------------------------------
    // sample pipeline
    // ----------------------------------------------------------------
    tnmc_pkg::tnmc_iq_type d1_q;
    tnmc_pkg::tnmc_iq_type d2_q;
    tnmc_pkg::tnmc_iq_type mix_q;
    tnmc_pkg::tnmc_iq_type fix_q;
    tnmc_pkg::tnmc_iq_type lvl_q;
    logic [tnmc_pkg::LATENCY-1:0] vld_q;
    logic rot1_q;
    logic rot2_q;
    logic signed [39:0] mix_i;
    logic signed [39:0] mix_q_w;

    // align samples with the two-clock phase-to-carrier delay
    always_ff @(posedge clk) begin
        if (!resetn) begin
            d1_q <= '0;
            d2_q <= '0;
            rot1_q <= 1'b0;
            rot2_q <= 1'b0;
        end else begin
            d1_q <= in_sample;
            d2_q <= d1_q;
            rot1_q <= rotate_en;
            rot2_q <= rot1_q;
        end
    end

    // complex product; carrier is all-pass so pass width is unchanged
    always_comb begin
        mix_i = 40'(d2_q.i) * 40'(cos_v) - 40'(d2_q.q) * 40'(sin_v);  // [R7]
        mix_q_w = 40'(d2_q.i) * 40'(sin_v) + 40'(d2_q.q) * 40'(cos_v);
    end

    // rotation, then mixing, then phase fix, level shift and scaling
    always_ff @(posedge clk) begin
        if (!resetn) begin
            mix_q <= '0;
            fix_q <= '0;
            lvl_q <= '0;
            out_sample_q <= '0;
        end else begin
            if (rot2_q) begin
                mix_q.i <= sat16(mix_i >>> 15);                   // [R7] [R21]
                mix_q.q <= sat16(mix_q_w >>> 15);                 // [R3] [R4]
            end else begin
                mix_q <= d2_q;
            end
            fix_q.i <= shear(mix_q.i, mix_q.q, i_phadj_q);        // [R10] [R12]
            fix_q.q <= shear(mix_q.q, mix_q.i, q_phadj_q);        // [R11] [R12]
            lvl_q.i <= sat16(40'(fix_q.i) + 40'(signed'(i_shift_q)));  // [R13]
            lvl_q.q <= sat16(40'(fix_q.q) + 40'(signed'(q_shift_q)));  // [R20]
            out_sample_q.i <= scale(lvl_q.i, i_scale_q);          // [R15] [R20]
            out_sample_q.q <= scale(lvl_q.q, q_scale_q);          // [R14] [R21]
        end
    end

    // valid follows the sample through every stage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            vld_q <= '0;
        end else begin
            vld_q <= {vld_q[tnmc_pkg::LATENCY-2:0], in_valid};
        end
    end
    assign out_valid = vld_q[tnmc_pkg::LATENCY-1];

endmodule
`default_nettype wire

// ===== tnmc_monitor.sv
// concurrent checks on the ports of the carrier and correction back end
// assumes it is bound into tnmc_top and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module tnmc_monitor (
    input wire logic clk,
    input wire logic resetn,
    input wire tnmc_pkg::tnmc_reg_req_type reg_req,
    input wire logic [7:0] reg_rdata_q,
    input wire logic in_valid,
    input wire tnmc_pkg::tnmc_iq_type in_sample,
    input wire logic [2:0] first_halfband_mode,
    input wire logic [2:0] second_halfband_mode,
    input wire logic out_valid,
    input wire tnmc_pkg::tnmc_iq_type out_sample_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [2:0] run_q;
    logic mode_wr;
    logic scl_wr;
    logic scl_rd;
    // cycles since release, so the latency check skips reset history
    always_ff @(posedge clk) begin
        if (!resetn) begin
            run_q <= 3'h0;
        end else if (run_q != 3'h7) begin
            run_q <= run_q + 3'h1;
        end
    end
    // decoded strobes
    assign mode_wr = reg_req.wr_en &&
        reg_req.addr == tnmc_pkg::ADDR_MODE_SELECT;
    assign scl_wr = reg_req.wr_en && reg_req.addr == tnmc_pkg::ADDR_I_SCALE;
    assign scl_rd = reg_req.rd_en && !reg_req.wr_en &&
        reg_req.addr == tnmc_pkg::ADDR_I_SCALE;
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_valid_latency: assert property (
        run_q == 3'h7 |-> out_valid == $past(in_valid, 6))
        else $error("out_valid not six cycles behind in_valid");
    chk_stage1_pair: assert property (
        mode_wr |=> first_halfband_mode ==
            {1'b0, $past(reg_req.wdata[0]), 1'b0})
        else $error("first stage mode not paired");
    chk_stage2_pair: assert property (
        mode_wr |=> second_halfband_mode ==
            {$past(reg_req.wdata[1:0]), 1'b0})
        else $error("second stage mode not paired");
    chk_mode_stable: assert property (
        !mode_wr |=> $stable(first_halfband_mode) &&
            $stable(second_halfband_mode))
        else $error("stage modes moved without a write");
    chk_unmapped_read: assert property (
        reg_req.rd_en && reg_req.addr < 8'h1e |=> reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
    chk_read_hold: assert property (
        !reg_req.rd_en |=> $stable(reg_rdata_q))
        else $error("read data moved without a read");
    chk_scale_readback: assert property (
        scl_wr ##1 scl_rd |=> reg_rdata_q == $past(reg_req.wdata, 2))
        else $error("scale factor read back wrong");
    chk_reset_clear: assert property (
        disable iff (1'b0) !resetn |=>
            !out_valid && out_sample_q == '0 && reg_rdata_q == 8'h00)
        else $error("outputs not cleared by reset");
    cover property (mode_wr && reg_req.wdata[2:0] == 3'h7);
    cover property (scl_wr ##1 scl_rd);
    cover property ($rose(out_valid));
endmodule
bind tnmc_top tnmc_monitor u_mon (
    .clk(clk),
    .resetn(resetn),
    .reg_req(reg_req),
    .reg_rdata_q(reg_rdata_q),
    .in_valid(in_valid),
    .in_sample(in_sample),
    .first_halfband_mode(first_halfband_mode),
    .second_halfband_mode(second_halfband_mode),
    .out_valid(out_valid),
    .out_sample_q(out_sample_q)
);
`default_nettype wire

// ===== tnmc_far_model.sv
// model of the i and q converters fed by the back end
// assumes out_sample_q is meant only in cycles where out_valid is high
`timescale 1ns/1ps
`default_nettype none
module tnmc_far_model (
    input wire logic clk,
    input wire logic out_valid,
    input wire tnmc_pkg::tnmc_iq_type out_sample_q,
    output logic [15:0] conv_i_q,
    output logic [15:0] conv_q_q
);
    // converters latch only tagged samples; stale values mark a gap
    always_ff @(posedge clk) begin
        if (out_valid) begin
            conv_i_q <= out_sample_q.i;
            conv_q_q <= out_sample_q.q;
        end
    end
endmodule
`default_nettype wire

// ===== tnmc_top_tb.sv
// self-checking bench for the carrier and correction back end
// assumes tnmc_top, tnmc_far_model and the bound monitor are compiled
`timescale 1ns/1ps
`default_nettype none
module tnmc_top_tb;
    typedef struct packed {
        logic [15:0] si; logic [15:0] sq; logic [15:0] li; logic [15:0] lq;
        logic [7:0] gi; logic [7:0] gq; logic [15:0] ei; logic [15:0] eq;
    } tnmc_row_type;
    // ------------------------------------------------------------
    // cases: sample, level shifts, scales, expected converter values
    // ------------------------------------------------------------
    localparam tnmc_row_type ROWS [7] = '{
        {64'h03e8f8300064ff9c, 16'h8080, 32'h0898ef98},
        {64'h75308ad01388ec78, 16'h4040, 32'h7fff8000},
        {64'h4e20b1e000000000, 16'hffff, 32'h7fff8000},
        {64'h03e8fc1800000000, 16'h0000, 32'h00000000},
        {64'hffc0006400000000, 16'h0102, 32'hffff0003},
        {64'h0003fffd00000000, 16'h3f3f, 32'h0002fffd},
        {64'h03e8fc1800000000, 16'h4040, 32'h03e8fc18}};
    logic clk, resetn, in_valid, out_valid;
    tnmc_pkg::tnmc_reg_req_type reg_req;
    tnmc_pkg::tnmc_iq_type in_sample, out_sample_q;
    logic [7:0] reg_rdata_q;
    logic [2:0] s1_mode, s2_mode;
    logic [15:0] conv_i, conv_q, prev;
    int num_errors, samples_checked;
    tnmc_top u_dut (.clk(clk), .resetn(resetn), .reg_req(reg_req),
        .reg_rdata_q(reg_rdata_q), .in_valid(in_valid),
        .in_sample(in_sample), .first_halfband_mode(s1_mode),
        .second_halfband_mode(s2_mode), .out_valid(out_valid),
        .out_sample_q(out_sample_q));
    tnmc_far_model u_far (.clk(clk), .out_valid(out_valid),
        .out_sample_q(out_sample_q), .conv_i_q(conv_i), .conv_q_q(conv_q));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // a request is held through one edge; the next call replaces it
    task automatic req(input logic w, input logic r, input logic [7:0] a,
        input logic [7:0] d);
        reg_req = '{w, r, a, d};
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req(1'b1, 1'b0, a, d);
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        req(1'b0, 1'b1, a, 8'h00);
        check({8'h00, reg_rdata_q}, {8'h00, exp});
    endtask
    // eight edges cover the fixed six-cycle pipe and the capture
    task automatic feed(input logic [15:0] i, input logic [15:0] q);
        in_sample = '{i, q};
        in_valid = 1'b1;
        repeat (8) @(posedge clk);
        #1;
    endtask
    // flip: carrier alternates each cycle; else it stands still
    task automatic pair_check(input logic flip);
        prev = conv_i;
        @(posedge clk);
        #1;
        check(flip ? conv_i + prev : conv_i, flip ? 16'h0000 : prev);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize;
    end
    initial begin
        resetn = 1'b0;
        reg_req = '0;
        in_valid = 1'b0;
        in_sample = '0;
        num_errors = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk);
        #1;
        resetn = 1'b1;
        rd_check(tnmc_pkg::ADDR_I_SCALE, 8'h40);
        rd_check(tnmc_pkg::ADDR_Q_SCALE, 8'h40);
        rd_check(tnmc_pkg::ADDR_STEP_B3, 8'h00);
        rd_check(8'h10, 8'h00);
        $display("test reset values done");
        // table loop; rows two and three push past full scale on purpose
        foreach (ROWS[k]) begin
            wr(tnmc_pkg::ADDR_I_SHIFT_LO, ROWS[k].li[7:0]);
            wr(tnmc_pkg::ADDR_I_SHIFT_HI, ROWS[k].li[15:8]);
            wr(tnmc_pkg::ADDR_Q_SHIFT_LO, ROWS[k].lq[7:0]);
            wr(tnmc_pkg::ADDR_Q_SHIFT_HI, ROWS[k].lq[15:8]);
            wr(tnmc_pkg::ADDR_I_SCALE, ROWS[k].gi);
            wr(tnmc_pkg::ADDR_Q_SCALE, ROWS[k].gq);
            feed(ROWS[k].si, ROWS[k].sq);
            check(conv_i, ROWS[k].ei);
            check(conv_q, ROWS[k].eq);
        end
        $display("test level and scale table done");
        wr(tnmc_pkg::ADDR_I_SCALE, 8'h40);
        rd_check(tnmc_pkg::ADDR_I_SCALE, 8'h40);
        wr(tnmc_pkg::ADDR_I_PHASE_LO, 8'hff);
        wr(tnmc_pkg::ADDR_I_PHASE_HI, 8'hff);
        rd_check(tnmc_pkg::ADDR_I_PHASE_HI, 8'h03);
        wr(tnmc_pkg::ADDR_I_PHASE_HI, 8'h01);
        wr(tnmc_pkg::ADDR_Q_PHASE_HI, 8'h02);
        feed(16'h4000, 16'h4000);
        check(conv_i, 16'h41f3);
        check(conv_q, 16'h3e0b);
        wr(tnmc_pkg::ADDR_I_PHASE_LO, 8'h00);
        wr(tnmc_pkg::ADDR_I_PHASE_HI, 8'h00);
        wr(tnmc_pkg::ADDR_Q_PHASE_HI, 8'h00);
        $display("test phase correction done");
        for (int n = 0; n < 8; n++) begin
            wr(tnmc_pkg::ADDR_MODE_SELECT, 8'(n));
            check({13'h0000, s1_mode}, 16'(2 * (n % 2)));
            check({13'h0000, s2_mode}, 16'((2 * n) % 8));
        end
        $display("test stage modes done");
        // loop left 28 eighths; 4 more close the turn, then step zero
        wr(tnmc_pkg::ADDR_MODE_SELECT, 8'h04);
        wr(tnmc_pkg::ADDR_MODE_SELECT, 8'h08);
        feed(16'h4000, 16'h2000);
        check(conv_i, 16'h3e5a);
        check(conv_q, 16'h231a);
        wr(tnmc_pkg::ADDR_SHIFT_HI, 8'h80);
        feed(16'h4000, 16'h2000);
        check(conv_i, 16'hc1a6);
        check(conv_q, 16'hdce6);
        wr(tnmc_pkg::ADDR_SHIFT_HI, 8'h00);
        wr(tnmc_pkg::ADDR_STEP_B3, 8'h80);
        feed(16'h4000, 16'h2000);
        pair_check(1'b0);
        wr(tnmc_pkg::ADDR_COMMIT, 8'h00);
        wr(tnmc_pkg::ADDR_COMMIT, 8'h04);
        feed(16'h4000, 16'h2000);
        pair_check(1'b1);
        wr(tnmc_pkg::ADDR_STEP_B3, 8'h00);
        wr(tnmc_pkg::ADDR_COMMIT, 8'h04);
        feed(16'h4000, 16'h2000);
        pair_check(1'b1);
        wr(tnmc_pkg::ADDR_COMMIT, 8'h00);
        wr(tnmc_pkg::ADDR_COMMIT, 8'h04);
        feed(16'h4000, 16'h2000);
        pair_check(1'b0);
        $display("test carrier and commit done");
        // second reset in mid-run with samples still flowing
        resetn = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        rd_check(tnmc_pkg::ADDR_Q_SCALE, 8'h40);
        check({15'h0000, out_valid}, 16'h0000);
        $display("test mid-run reset done");
        summarize;
    end
endmodule
`default_nettype wire
